// ==== hw/lcdsid_device.sv ====
/*
 * serial instruction receiver and decoder of the display controller.
 * assumes link pins asynchronous to pclk and shift clock far below pclk/4.
 */
// Summary of operation
// R1: address 42h opens each frame
// R2: shift rise samples, select fall commits
// R3: host gap exceeds execution
// R4: technique first, runs 108 us
// R5: others run 27 us, clock scaled
// R6: opcode 1, duty picks shared pin
// R7: rate bits pick frame divisor
// R8: source bit picks RC or external
// R9: opcode 2 sets digits and controls
// R10: matrix/aux pair gates digits
// R11: one enable bit per digit
// R12: blank forces lowest bias
// R13: sleep blanks, stops clock but scan
// R14: sleep admits only on/off
// R15: external clock outlives execution
// R16: opcode 3, pair picks shifted data
// R17: direction 0 left, 1 right
// R18: opcode 4 loads both pointers
// R19: write frames carry increment mode
// R20: pointer feeds display ram addresses
// R21: character shift wraps 33h and 0
// R22: inhibit keeps reception running
// R23: bad address or opcode changes nothing
`timescale 1ns/1ps
module lcdsid_device #(
    parameter int DISP_KHZ  = lcdsid_pkg::REF_KHZ,
    parameter int EXEC_CYC  = lcdsid_pkg::exec_cycles(lcdsid_pkg::EXEC_US, DISP_KHZ),
    parameter int FIRST_CYC = lcdsid_pkg::exec_cycles(lcdsid_pkg::FIRST_US, DISP_KHZ)
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // link
    lcdsid_if.device         link,
    // side inputs
    input  wire logic        key_scan_active,
    input  wire logic        display_inhibit_n,
    // display state
    output logic             busy,
    output logic             duty_select,
    output logic [1:0]       frame_rate,
    output logic [11:0]      frame_divisor,
    output logic             clock_source_select,
    output logic             osc_run,
    output logic             drive_lowest_bias,
    output logic [12:0]      matrix_digit_en,
    output logic [12:0]      aux_digit_en,
    output logic [5:0]       char_ram_address,
    output logic [3:0]       aux_ram_address,
    output logic [1:0]       increment_mode
);
    // ********
    // helpers
    // ********
    function automatic logic [5:0] rot(input logic [5:0] p, input logic [5:0] last,
                                       input logic right);
        if (right) begin
            return (p == 6'h00) ? last : p - 6'h01;
        end
        return (p == last) ? 6'h00 : p + 6'h01;
    endfunction : rot

    function automatic logic [11:0] fdiv(input logic d, input logic [1:0] fr);
        unique case ({d, fr})
            3'b000:  return lcdsid_pkg::DIV8_00;
            3'b001:  return lcdsid_pkg::DIV8_10;
            3'b010:  return lcdsid_pkg::DIV8_01;
            3'b100:  return lcdsid_pkg::DIV9_00;
            3'b101:  return lcdsid_pkg::DIV9_10;
            3'b110:  return lcdsid_pkg::DIV9_01;
            default: return d ? lcdsid_pkg::DIV9_00 : lcdsid_pkg::DIV8_00;
        endcase
    endfunction : fdiv

    // ********
    // pin synchronisers and shift registers
    // ********
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [1:0] s3_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 2'h0;
        end else if (clk_en) begin
            s1_q <= {display_inhibit_n, link.serial_data_in,
                     link.serial_shift_clock, link.frame_sel};
            s2_q <= s1_q;
            s3_q <= s2_q[1:0];
        end
    end

    logic sel_s;
    logic sclk_rise;
    logic sel_fall;
    assign sel_s     = s2_q[0];
    assign sclk_rise = s2_q[1] & ~s3_q[1];
    assign sel_fall  = ~s2_q[0] & s3_q[0];

    logic [lcdsid_pkg::ADDR_W-1:0] addr_q;
    logic [lcdsid_pkg::DATA_W-1:0] data_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= '0;
            data_q <= '0;
        end else if (clk_en && sclk_rise) begin
            // last bit lands at the top so short frames align to D119 [R2]
            if (sel_s) begin
                data_q <= {s2_q[2], data_q[lcdsid_pkg::DATA_W-1:1]};
            end else begin
                addr_q <= {s2_q[2], addr_q[lcdsid_pkg::ADDR_W-1:1]};
            end
        end
    end

    // ********
    // decode and execution timer
    // ********
    localparam int BUSY_W_L = lcdsid_pkg::BUSY_W;
    logic [3:0]            opc;
    logic                  known;
    logic                  commit;
    logic [BUSY_W_L-1:0]   busy_cnt_q;
    logic                  tech_done_q;
    logic                  sleep_q;

    assign opc   = data_q[lcdsid_pkg::OPC_LSB +: lcdsid_pkg::OPC_W];
    assign known = (opc == lcdsid_pkg::OPC_TECH) || (opc == lcdsid_pkg::OPC_ONOFF) ||
                   (opc == lcdsid_pkg::OPC_SHIFT) || (opc == lcdsid_pkg::OPC_SETAC) ||
                   (opc == lcdsid_pkg::OPC_WRITE);                          // [R23]
    // frames during execution are dropped: the host owes the gap [R3]
    // reception keeps running whatever the inhibit input says [R22]
    assign commit = sel_fall && (addr_q == lcdsid_pkg::DEV_ADDR) && known &&
                    (busy_cnt_q == '0) &&                                   // [R1] [R2]
                    (!sleep_q || opc == lcdsid_pkg::OPC_ONOFF);             // [R14]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_q  <= '0;
            tech_done_q <= 1'b0;
        end else if (clk_en) begin
            if (commit) begin
                if (opc == lcdsid_pkg::OPC_TECH && !tech_done_q) begin
                    busy_cnt_q <= BUSY_W_L'(FIRST_CYC);                     // [R4]
                end else begin
                    busy_cnt_q <= BUSY_W_L'(EXEC_CYC);                      // [R5]
                end
                if (opc == lcdsid_pkg::OPC_TECH) begin
                    tech_done_q <= 1'b1;
                end
            end else if (busy_cnt_q != '0) begin
                busy_cnt_q <= busy_cnt_q - BUSY_W_L'(1);
            end
        end
    end

    // ********
    // instruction state
    // ********
    logic        duty_q;
    logic [1:0]  frate_q;
    logic        osc_ext_q;
    logic [12:0] digit_q;
    logic        mat_q;
    logic        aux_q;
    logic        blank_q;
    logic [5:0]  cptr_q;
    logic [3:0]  aptr_q;
    logic [1:0]  imode_q;
    logic [5:0]  aptr_w;

    assign aptr_w = {2'b00, aptr_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_q    <= 1'b0;
            frate_q   <= 2'b00;
            osc_ext_q <= 1'b0;
            digit_q   <= '0;
            mat_q     <= 1'b0;
            aux_q     <= 1'b0;
            blank_q   <= 1'b0;
            sleep_q   <= 1'b0;
            cptr_q    <= '0;
            aptr_q    <= '0;
            imode_q   <= 2'b00;
        end else if (clk_en && commit) begin
            unique case (opc)
                lcdsid_pkg::OPC_TECH: begin
                    duty_q    <= data_q[lcdsid_pkg::DUTY_POS];              // [R6]
                    frate_q   <= {data_q[lcdsid_pkg::FR_HI_POS],
                                  data_q[lcdsid_pkg::FR_LO_POS]};           // [R7]
                    osc_ext_q <= data_q[lcdsid_pkg::OSC_POS];               // [R8]
                end
                lcdsid_pkg::OPC_ONOFF: begin
                    digit_q <= data_q[lcdsid_pkg::DG_LSB +: lcdsid_pkg::DG_W]; // [R9]
                    mat_q   <= data_q[lcdsid_pkg::M_POS];
                    aux_q   <= data_q[lcdsid_pkg::A_POS];
                    blank_q <= data_q[lcdsid_pkg::BLANK_POS];
                    sleep_q <= data_q[lcdsid_pkg::SLEEP_POS];
                end
                lcdsid_pkg::OPC_SHIFT: begin
                    if (data_q[lcdsid_pkg::M_POS]) begin                    // [R16]
                        cptr_q <= rot(cptr_q, lcdsid_pkg::CHAR_LAST,
                                      data_q[lcdsid_pkg::DIR_POS]);         // [R17] [R21]
                    end
                    if (data_q[lcdsid_pkg::A_POS]) begin
                        aptr_q <= 4'(rot(aptr_w, lcdsid_pkg::AUX_LAST,
                                         data_q[lcdsid_pkg::DIR_POS])); // [R17]
                    end
                end
                lcdsid_pkg::OPC_SETAC: begin
                    cptr_q <= data_q[lcdsid_pkg::CA_LSB +: lcdsid_pkg::CA_W]; // [R18]
                    aptr_q <= data_q[lcdsid_pkg::AA_LSB +: lcdsid_pkg::AA_W];
                end
                lcdsid_pkg::OPC_WRITE: begin
                    // ram contents live elsewhere; only the increment mode is kept
                    imode_q <= {data_q[lcdsid_pkg::IM2_POS],
                                data_q[lcdsid_pkg::IM1_POS]};               // [R19]
                end
                default: begin
                end
            endcase
        end
    end

    // ********
    // registered outputs
    // ********
    logic quiet;
    assign quiet = blank_q | sleep_q | ~s2_q[3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy                <= 1'b0;
            duty_select         <= 1'b0;
            frame_rate          <= 2'b00;
            frame_divisor       <= lcdsid_pkg::DIV8_00;
            clock_source_select <= 1'b0;
            osc_run             <= 1'b1;
            drive_lowest_bias   <= 1'b1;
            matrix_digit_en     <= '0;
            aux_digit_en        <= '0;
            char_ram_address    <= '0;
            aux_ram_address     <= '0;
            increment_mode      <= 2'b00;
        end else if (clk_en) begin
            busy                <= (busy_cnt_q != '0);
            duty_select         <= duty_q;                                  // [R6]
            frame_rate          <= frate_q;
            frame_divisor       <= fdiv(duty_q, frate_q);                   // [R7]
            clock_source_select <= osc_ext_q;                               // [R8]
            // the clock must outlive the sleep instruction itself
            osc_run             <= ~sleep_q | key_scan_active | (busy_cnt_q != '0); // [R13]
            drive_lowest_bias   <= quiet;                                   // [R12] [R13]
            matrix_digit_en     <= (mat_q && !quiet) ? digit_q : '0;        // [R10] [R11]
            aux_digit_en        <= (aux_q && !quiet) ? digit_q : '0;        // [R10] [R11]
            char_ram_address    <= cptr_q;                                  // [R20]
            aux_ram_address     <= aptr_q;                                  // [R20]
            increment_mode      <= imode_q;
        end
    end
endmodule : lcdsid_device

// ==== hw/lcdsid_pkg.sv ====
/*
 * constants shared by both ends of the serial instruction link.
 * assumes pclk at CLK_MHZ; no other dependency.
 */
package lcdsid_pkg;
    // ********
    // link framing and fields
    // ********
    localparam logic [7:0] DEV_ADDR  = 8'h42;
    localparam int         ADDR_W    = 8;
    localparam int         DATA_W    = 24;
    // field positions, index 0 is D96
    localparam int OPC_LSB   = 20;
    localparam int OPC_W     = 4;
    localparam int DUTY_POS  = 16;
    localparam int FR_LO_POS = 17;
    localparam int FR_HI_POS = 18;
    localparam int OSC_POS   = 19;
    localparam int DG_LSB    = 0;
    localparam int DG_W      = 13;
    localparam int M_POS     = 16;
    localparam int A_POS     = 17;
    localparam int BLANK_POS = 18;
    localparam int SLEEP_POS = 19;
    localparam int DIR_POS   = 18;
    localparam int CA_LSB    = 8;
    localparam int CA_W      = 6;
    localparam int AA_LSB    = 16;
    localparam int AA_W      = 4;
    localparam int IM1_POS   = 16;
    localparam int IM2_POS   = 17;
    // ********
    // opcodes, divisors, wrap
    // ********
    localparam logic [3:0] OPC_TECH  = 4'h1;
    localparam logic [3:0] OPC_ONOFF = 4'h2;
    localparam logic [3:0] OPC_SHIFT = 4'h3;
    localparam logic [3:0] OPC_SETAC = 4'h4;
    localparam logic [3:0] OPC_WRITE = 4'h5;
    localparam logic [11:0] DIV8_00 = 12'hC00;
    localparam logic [11:0] DIV8_10 = 12'h600;
    localparam logic [11:0] DIV8_01 = 12'h300;
    localparam logic [11:0] DIV9_00 = 12'hD80;
    localparam logic [11:0] DIV9_10 = 12'h6C0;
    localparam logic [11:0] DIV9_01 = 12'h360;
    localparam logic [5:0]  CHAR_LAST = 6'h33;
    localparam logic [5:0]  AUX_LAST  = 6'h0C;
    // ********
    // timing and host registers
    // ********
    localparam int CLK_MHZ  = 100;
    localparam int REF_KHZ  = 300;
    localparam int EXEC_US  = 27;
    localparam int FIRST_US = 108;
    localparam int BUSY_W   = 24;
    localparam logic [11:0] REG_TXDATA = 12'h000;
    localparam logic [11:0] REG_TXLEN  = 12'h004;
    localparam logic [11:0] REG_CMD    = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam logic [11:0] REG_ADDR   = 12'h010;
    localparam int CMD_GO    = 0;
    localparam int CMD_IDLEH = 1;

    // cycles of pclk for a time in us at display clock khz
    function automatic int exec_cycles(input int us, input int khz);
        return us * CLK_MHZ * REF_KHZ / khz;
    endfunction : exec_cycles
endpackage : lcdsid_pkg

// ==== hw/lcdsid_if.sv ====
/*
 * three-wire serial instruction link between host and device.
 * assumes both ends on one pclk; the device resynchronises anyway.
 */
`timescale 1ns/1ps
interface lcdsid_if;
    logic frame_sel;
    logic serial_shift_clock;
    logic serial_data_in;

    modport host (
        output frame_sel,
        output serial_shift_clock,
        output serial_data_in
    );
    modport device (
        input  frame_sel,
        input  serial_shift_clock,
        input  serial_data_in
    );
endinterface : lcdsid_if

// ==== hw/lcdsid_host.sv ====
/*
 * host end: apb registers take an instruction and shift it out on the link.
 * assumes software keeps order; illegal orders are refused.
 */
`timescale 1ns/1ps
module lcdsid_host #(
    parameter int CLK_DIV   = 8,
    parameter int GAP_CYC   = 3000,
    parameter int FIRST_GAP = 11000
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // link
    lcdsid_if.host           link
);
    typedef enum logic [2:0] {H_IDLE, H_ADDR, H_CE_UP, H_DATA, H_CE_DN, H_GAP} lcdsid_hst_t;

    lcdsid_hst_t st_q;
    logic [23:0] txd_q;
    logic [4:0]  len_q;
    logic [7:0]  dadr_q;
    logic        idleh_q;
    logic        refuse_q;
    logic        tech_q;
    logic        sleep_q;
    logic [4:0]  idx_q;
    logic        half_q;
    logic [15:0] div_q;
    logic [23:0] gap_q;
    logic        first_q;
    logic        tick;
    logic        wr;
    logic        go;
    logic [3:0]  opc;
    logic        bad;

    // ********
    // apb slave, one wait state
    // ********
    assign wr  = psel & penable & pready & pwrite;
    assign go  = wr && paddr == lcdsid_pkg::REG_CMD && pwdata[lcdsid_pkg::CMD_GO];
    assign opc = txd_q[lcdsid_pkg::OPC_LSB +: lcdsid_pkg::OPC_W];
    assign bad = (st_q != H_IDLE) ||
                 !(len_q == 5'd8 || len_q == 5'd16 || len_q == 5'd24) ||
                 (!tech_q && opc != lcdsid_pkg::OPC_TECH) ||                // [R4]
                 (sleep_q && opc != lcdsid_pkg::OPC_ONOFF);                 // [R14]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel & penable & ~pready;
            if (psel && penable && !pready && !pwrite) begin
                unique case (paddr)
                    lcdsid_pkg::REG_TXDATA: prdata <= {8'h00, txd_q};
                    lcdsid_pkg::REG_TXLEN:  prdata <= {27'h0, len_q};
                    lcdsid_pkg::REG_ADDR:   prdata <= {24'h0, dadr_q};
                    lcdsid_pkg::REG_STATUS: prdata <= {27'h0, idleh_q, sleep_q, tech_q,
                                                       refuse_q, st_q != H_IDLE};
                    default:                prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_q   <= '0;
            len_q   <= 5'd24;
            dadr_q  <= lcdsid_pkg::DEV_ADDR;                                 // [R1]
            idleh_q <= 1'b0;
        end else if (clk_en && wr) begin
            if (paddr == lcdsid_pkg::REG_TXDATA) txd_q <= pwdata[23:0];
            if (paddr == lcdsid_pkg::REG_TXLEN) len_q <= pwdata[4:0];
            if (paddr == lcdsid_pkg::REG_ADDR) dadr_q <= pwdata[7:0];
            if (paddr == lcdsid_pkg::REG_CMD && st_q == H_IDLE) begin
                idleh_q <= pwdata[lcdsid_pkg::CMD_IDLEH];                   // [R2]
            end
        end
    end

    // ********
    // link sequencer
    // ********
    assign tick = (div_q == 16'(CLK_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= H_IDLE;
            div_q    <= '0;
            half_q   <= 1'b0;
            idx_q    <= '0;
            gap_q    <= '0;
            first_q  <= 1'b0;
            refuse_q <= 1'b0;
            tech_q   <= 1'b0;
            sleep_q  <= 1'b0;
            link.frame_sel          <= 1'b0;
            link.serial_shift_clock <= 1'b0;
            link.serial_data_in     <= 1'b0;
        end else if (clk_en) begin
            div_q <= (tick || st_q == H_IDLE) ? 16'h0000 : div_q + 16'h0001;
            unique case (st_q)
                H_IDLE: begin
                    link.serial_shift_clock <= idleh_q;
                    if (go) begin
                        refuse_q <= bad;
                        if (!bad) begin
                            st_q    <= H_ADDR;
                            idx_q   <= '0;
                            half_q  <= 1'b0;
                            first_q <= (opc == lcdsid_pkg::OPC_TECH) && !tech_q;
                            if (opc == lcdsid_pkg::OPC_TECH) tech_q <= 1'b1;
                            if (opc == lcdsid_pkg::OPC_ONOFF) begin
                                sleep_q <= txd_q[lcdsid_pkg::SLEEP_POS];
                            end
                        end
                    end
                end
                H_ADDR, H_DATA: if (tick) begin
                    // data moves with the clock low
                    if (!half_q) begin
                        link.serial_shift_clock <= 1'b0;                    // [R2]
                        link.serial_data_in <= (st_q == H_ADDR) ? dadr_q[idx_q[2:0]]
                                                                : txd_q[idx_q];
                        half_q <= 1'b1;
                    end else begin
                        link.serial_shift_clock <= 1'b1;
                        half_q <= 1'b0;
                        idx_q  <= idx_q + 5'd1;
                        if (st_q == H_ADDR && idx_q == 5'd7) st_q <= H_CE_UP;
                        if (st_q == H_DATA && idx_q == 5'd23) st_q <= H_CE_DN;
                    end
                end
                H_CE_UP: if (tick) begin
                    link.frame_sel <= 1'b1;
                    idx_q <= 5'd24 - len_q;
                    st_q  <= H_DATA;
                end
                H_CE_DN: if (tick) begin
                    link.serial_shift_clock <= idleh_q;
                    link.frame_sel <= 1'b0;                                 // [R2]
                    gap_q <= first_q ? 24'(FIRST_GAP) : 24'(GAP_CYC);       // [R3] [R4]
                    st_q  <= H_GAP;
                end
                H_GAP: begin
                    // gap covers execution, so an external clock may stop after it
                    if (gap_q == '0) st_q <= H_IDLE;                        // [R3] [R15]
                    else gap_q <= gap_q - 24'h000001;
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule : lcdsid_host

// ==== test/lcdsid_properties.sv ====
/* link and display-state checks beside the link.
   assumes one pclk domain and the bench's shortened counts. */
`timescale 1ns/1ps
module lcdsid_properties #(parameter int EXEC_CYC = 200, parameter int FIRST_CYC = 300) (
    input logic        pclk,
    input logic        presetn,
    input logic        frame_sel,
    input logic        serial_shift_clock,
    input logic        serial_data_in,
    input logic        display_inhibit_n,
    input logic        key_scan_active,
    input logic        busy,
    input logic        duty_select,
    input logic [1:0]  frame_rate,
    input logic [11:0] frame_divisor,
    input logic        osc_run,
    input logic        drive_lowest_bias,
    input logic [5:0]  char_ram_address
);
    logic [7:0]  sf_q;
    logic [9:0]  bl_q;
    logic [11:0] div_exp;
    // select-fall age, saturating
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) sf_q <= 8'hFF;
        else if ($fell(frame_sel)) sf_q <= 8'h00;
        else if (sf_q != 8'hFF) sf_q <= sf_q + 8'h01;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) bl_q <= 10'h000;
        else bl_q <= busy ? bl_q + 10'h001 : 10'h000;
    assign div_exp = (duty_select ? 12'hD80 : 12'hC00) >>
                     (frame_rate == 2'b01 ? 1 : frame_rate == 2'b10 ? 2 : 0);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_dat; $changed(serial_data_in) |-> !serial_shift_clock; endproperty
    a_dat: assert property (p_dat)
        else $error("data moved with shift clock high");
    property p_cause; $rose(busy) |-> sf_q < 8'h08; endproperty
    a_cause: assert property (p_cause)
        else $error("execution without select fall");
    property p_len; $fell(busy) |-> bl_q == EXEC_CYC || bl_q == FIRST_CYC; endproperty
    a_len: assert property (p_len)
        else $error("execution length wrong");
    property p_gap; busy |-> !$rose(frame_sel); endproperty
    a_gap: assert property (p_gap)
        else $error("frame started during execution");
    property p_hold; sf_q > 8'h0C |-> $stable({duty_select, frame_rate, char_ram_address}); endproperty
    a_hold: assert property (p_hold)
        else $error("state moved without a frame");
    property p_div; sf_q > 8'h0C |-> frame_divisor == div_exp; endproperty
    a_div: assert property (p_div)
        else $error("frame divisor wrong");
    property p_inh; !display_inhibit_n [*4] |-> drive_lowest_bias; endproperty
    a_inh: assert property (p_inh)
        else $error("outputs not quiet under inhibit");
    property p_osc; key_scan_active [*2] |-> osc_run; endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator stopped during scan");
    c_exec: cover property ($rose(busy));
    c_duty: cover property ($rose(duty_select));
    c_wrap: cover property (char_ram_address == 6'h33);
endmodule : lcdsid_properties

// ==== test/lcdsid_tb_top.sv ====
/* bench: host and device on one link, host over apb.
   assumes the hw files compile first. */
`timescale 1ns/1ps
module lcdsid_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, busy, duty_select, osc_run;
    logic        clock_source_select, drive_lowest_bias, key_scan_active, display_inhibit_n;
    logic [11:0] paddr, frame_divisor;
    logic [31:0] pwdata, prdata, st;
    logic [12:0] matrix_digit_en, aux_digit_en;
    logic [5:0]  char_ram_address;
    logic [3:0]  aux_ram_address;
    logic [1:0]  frame_rate, increment_mode;
    logic        clk_en, pslverr;
    int          fails, check_count;
    localparam logic [11:0] DV [6] = '{12'hC00, 12'h600, 12'h300, 12'hD80, 12'h6C0, 12'h360};
    lcdsid_if lcdsid_if_i ();
    lcdsid_host #(.GAP_CYC(300), .FIRST_GAP(400)) lcdsid_host_i (.pclk, .presetn, .clk_en,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .link(lcdsid_if_i.host));
    lcdsid_device #(.EXEC_CYC(200), .FIRST_CYC(300)) lcdsid_device_i (.pclk, .presetn,
        .clk_en, .link(lcdsid_if_i.device), .key_scan_active, .display_inhibit_n, .busy,
        .duty_select, .frame_rate, .frame_divisor, .clock_source_select, .osc_run,
        .drive_lowest_bias, .matrix_digit_en, .aux_digit_en, .char_ram_address,
        .aux_ram_address, .increment_mode);
    lcdsid_properties lcdsid_properties_i (.pclk, .presetn,
        .frame_sel(lcdsid_if_i.frame_sel), .serial_shift_clock(lcdsid_if_i.serial_shift_clock),
        .serial_data_in(lcdsid_if_i.serial_data_in), .display_inhibit_n, .key_scan_active,
        .busy, .duty_select, .frame_rate, .frame_divisor, .osc_run, .drive_lowest_bias,
        .char_ram_address);
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    // one apb transfer; read data lands in st
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        st = prdata;
        {psel, penable} <= 2'b00;
    endtask : apb
    // polls status until idle again
    task automatic send(input logic [23:0] d, input logic [31:0] cmd);
        apb(1'b1, 12'h000, {8'h00, d});
        apb(1'b1, 12'h008, cmd);
        do apb(1'b0, 12'h00C, 32'h0); while (st[0] !== 1'b0);
    endtask : send
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #400000;
        fails++;
        final_report();
    end
    initial begin
        {presetn, psel, penable, pwrite, key_scan_active, paddr, pwdata} = '0;
        {clk_en, display_inhibit_n} = 2'b11;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset", {osc_run, drive_lowest_bias, frame_divisor}, {2'b11, DV[0]});
        apb(1'b0, 12'h010, 32'h0);
        chk("address", st, 32'h42);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", st, 32'h0);
        chk("slverr", pslverr, 1'b0);
        send({4'h2, 20'h0}, 32'h1);
        chk("first", st[1], 1'b1);
        for (int i = 0; i < 6; i++) begin
            send({4'h1, i[0], i % 3 == 2, i % 3 == 1, i > 2, 16'h0}, i == 5 ? 32'h3 : 32'h1);
            chk("divisor", frame_divisor, DV[i]);
            chk("technique", {duty_select, clock_source_select}, {i > 2, i[0]});
        end
        apb(1'b1, 12'h010, 32'h43);
        send({4'h1, 20'h0}, 32'h1);
        apb(1'b1, 12'h010, 32'h42);
        send({4'h7, 20'h0}, 32'h1);
        chk("dropped", frame_divisor, DV[5]);
        for (int i = 0; i < 4; i++) begin
            send({4'h2, 2'b00, i[0], i[1], 3'b000, 13'h1A5B}, 32'h1);
            chk("matrix", matrix_digit_en, i[1] ? 13'h1A5B : 13'h0);
            chk("aux", aux_digit_en, i[0] ? 13'h1A5B : 13'h0);
        end
        chk("normal", drive_lowest_bias, 1'b0);
        send({4'h2, 4'b0111, 16'h1A5B}, 32'h1);
        chk("blank", drive_lowest_bias, 1'b1);
        send({4'h2, 4'b1011, 16'h1A5B}, 32'h1);
        chk("sleep", {drive_lowest_bias, osc_run}, 2'b10);
        key_scan_active <= 1'b1;
        send({4'h4, 20'h0}, 32'h1);
        chk("refused", st[1], 1'b1);
        key_scan_active <= 1'b0;
        send({4'h2, 4'b0011, 16'h1FFF}, 32'h1);
        display_inhibit_n <= 1'b0;
        send({4'h4, 4'hA, 2'b00, 6'h2E, 8'h00}, 32'h1);
        chk("pointer", {char_ram_address, aux_ram_address, drive_lowest_bias}, 11'h5D5);
        display_inhibit_n <= 1'b1;
        send({4'h4, 20'h0}, 32'h1);
        send({4'h3, 4'b0111, 16'h0}, 32'h1);
        chk("right", {char_ram_address, aux_ram_address}, {6'h33, 4'hC});
        send({4'h3, 4'b0001, 16'h0}, 32'h1);
        chk("left", {char_ram_address, aux_ram_address}, {6'h00, 4'hC});
        send({4'h5, 4'b0010, 16'h0}, 32'h1);
        chk("incmode", increment_mode, 2'b10);
        final_report();
    end
endmodule : lcdsid_tb_top
